// file: hw/rsso_pkg.sv
// constants, field layouts and carrier types for the rotate/subtract/sleep
// datapath; assumes a 32-bit APB slave with byte addresses below 8'h20
`default_nettype none

package rsso_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FADDR = 8'h0c;
  localparam logic [7:0] OFS_FDATA = 8'h10;
  localparam logic [7:0] OFS_WAKE = 8'h14;
  localparam logic [7:0] OFS_WDOG = 8'h18;

  // ----------------------------------------------------------------
  // datapath sizes
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FILE_AW = 7;
  localparam int unsigned FILE_DEPTH = 128;
  localparam logic [6:0] FILE_ADDR_MAX = 7'h7f;
  localparam logic [7:0] LITERAL_MAX = 8'hff;

  // ----------------------------------------------------------------
  // instruction word written to OFS_INSTR
  // ----------------------------------------------------------------
  localparam logic [1:0] OPC_ROTATE_LEFT_THRU_CARRY = 2'h0;
  localparam logic [1:0] OPC_ROTATE_RIGHT_THRU_CARRY = 2'h1;
  localparam logic [1:0] OPC_LITERAL_MINUS_ACC = 2'h2;
  localparam logic [1:0] OPC_SLEEP = 2'h3;
  localparam int unsigned INSTR_OP_LSB = 12;
  localparam int unsigned INSTR_DEST_BIT = 8;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef struct packed {
    logic [1:0] op;
    logic [2:0] rsvd;
    logic dest;
    logic [7:0] operand;
  } rsso_instr_t;

  // ----------------------------------------------------------------
  // status register layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned ST_CARRY = 0;
  localparam int unsigned ST_NIBBLE_CARRY = 1;
  localparam int unsigned ST_ZERO = 2;
  localparam int unsigned ST_POWER_DOWN = 3;
  localparam int unsigned ST_TIMEOUT = 4;
  localparam int unsigned ST_ASLEEP = 5;
  localparam logic RST_POWER_DOWN = 1'b1;
  localparam logic RST_TIMEOUT = 1'b1;

  // order matches ST_* positions, bit 4 down to bit 0
  typedef struct packed {
    logic timeoutStatus;
    logic powerDownStatus;
    logic zero;
    logic nibbleCarryFlag;
    logic carry;
  } rsso_flags_t;

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  localparam int unsigned WDOG_PRE_W = 8;
  localparam int unsigned WDOG_CNT_W = 8;
  localparam logic [7:0] WDOG_PRE_LAST = 8'hff;
  localparam logic [7:0] WDOG_CNT_LAST = 8'hff;
  localparam logic [7:0] WDOG_CLEAR_VALUE = 8'h00;
  localparam int unsigned WDOG_CNT_LSB = 8;

  // ----------------------------------------------------------------
  // handshake states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_ROTATE, S_FILE_READ} rsso_state_t;

endpackage

`default_nettype wire

// file: hw/rsso_file_mem.sv
// file register array, 128 bytes, one write port and a registered read
// assumes a single clock; read data reflect the address of the prior edge
`timescale 1ns/1ps
`default_nettype none

module rsso_file_mem (
  input wire logic mclk,
  input wire logic wrEn,
  input wire logic [6:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [6:0] rdAddr,
  output logic [7:0] rdData
);

  logic [7:0] mem [rsso_pkg::FILE_DEPTH];

  // a read in the same cycle as a write to the same byte returns old data
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk) begin
    rdData <= mem[rdAddr];
  end

endmodule // rsso_file_mem

`default_nettype wire

// file: hw/rsso_watchdog_counter.sv
// watchdog counter with its prescaler; prescaler counts on every mclk edge, counter once per prescaler wrap
// assumes clear is a one-cycle strobe from the execution logic
`timescale 1ns/1ps
`default_nettype none

module rsso_watchdog_counter (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  output logic [7:0] prescale,
  output logic [7:0] count,
  output logic overflow
);

  logic preWrap;

  assign preWrap = (prescale == rsso_pkg::WDOG_PRE_LAST);

  // --------------------------------------------------------------
  // prescaler and counter, clear wins over counting
  // --------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst || clear) begin
      prescale <= rsso_pkg::WDOG_CLEAR_VALUE;
    end else begin
      prescale <= prescale + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || clear) begin
      count <= rsso_pkg::WDOG_CLEAR_VALUE;
    end else if (preWrap) begin
      count <= count + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || clear) begin
      overflow <= 1'b0;
    end else begin
      overflow <= preWrap && (count == rsso_pkg::WDOG_CNT_LAST);
    end
  end

endmodule // rsso_watchdog_counter

`default_nettype wire

// file: hw/rsso_core.sv
// APB-reached execution unit for rotate, literal subtract and sleep
// assumes an APB master on mclk; one instruction is issued per write
`timescale 1ns/1ps
`default_nettype none

module rsso_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic oscRunning
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rsso_pkg::rsso_state_t state_q;
  rsso_pkg::rsso_instr_t instr_q;
  rsso_pkg::rsso_flags_t flags_q;
  logic [7:0] acc_q;
  logic [6:0] faddr_q;
  logic asleep_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  rsso_pkg::rsso_instr_t busInstr;
  logic access;
  logic mapped;
  logic isInstr;
  logic issueNow;
  logic refuseNow;
  logic swWrAcc;
  logic swWrStatus;
  logic swWrFaddr;
  logic swWrFdata;
  logic swWake;
  logic [31:0] regRd;
  logic [7:0] wdogPre;
  logic [7:0] wdogCount;

  assign busInstr = rsso_pkg::rsso_instr_t'(pwdata[13:0]);
  // pready low keeps one transfer from being taken twice
  assign access = psel && penable && !pready && (state_q == rsso_pkg::S_IDLE);
  assign isInstr = (paddr == rsso_pkg::OFS_INSTR);
  assign issueNow = access && pwrite && isInstr && !asleep_q;
  assign refuseNow = access && pwrite && isInstr && asleep_q;
  assign swWrAcc = access && pwrite && (paddr == rsso_pkg::OFS_ACC);
  assign swWrStatus = access && pwrite && (paddr == rsso_pkg::OFS_STATUS);
  assign swWrFaddr = access && pwrite && (paddr == rsso_pkg::OFS_FADDR);
  assign swWrFdata = access && pwrite && (paddr == rsso_pkg::OFS_FDATA);
  assign swWake = access && pwrite && (paddr == rsso_pkg::OFS_WAKE) &&
                  pwdata[0];

  always_comb begin
    mapped = 1'b1;
    regRd = 32'h0000_0000;
    case (paddr)
      rsso_pkg::OFS_INSTR: regRd = {18'h00000, instr_q};
      rsso_pkg::OFS_ACC: regRd = {24'h000000, acc_q};
      rsso_pkg::OFS_STATUS: regRd = {26'h0000000, asleep_q, flags_q};
      rsso_pkg::OFS_FADDR: regRd = {25'h0000000, faddr_q};
      rsso_pkg::OFS_FDATA: regRd = 32'h0000_0000;
      rsso_pkg::OFS_WAKE: regRd = {31'h00000000, asleep_q};
      rsso_pkg::OFS_WDOG: regRd = {16'h0000, wdogCount, wdogPre};
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // execution strobes
  // ----------------------------------------------------------------
  logic execSub;
  logic execSleep;
  logic execRot;
  logic rotLeft;

  // subtract and sleep act at the edge that takes the bus write
  assign execSub = issueNow &&
                   (busInstr.op == rsso_pkg::OPC_LITERAL_MINUS_ACC);
  assign execSleep = issueNow && (busInstr.op == rsso_pkg::OPC_SLEEP);
  // rotates wait one edge for the file byte, then finish in one cycle
  assign execRot = (state_q == rsso_pkg::S_ROTATE);
  assign rotLeft = (instr_q.op == rsso_pkg::OPC_ROTATE_LEFT_THRU_CARRY);

  // ----------------------------------------------------------------
  // file array and watchdog
  // ----------------------------------------------------------------
  logic fileWrEn;
  logic [6:0] fileWrAddr;
  logic [7:0] fileWrData;
  logic [6:0] fileRdAddr;
  logic [7:0] fileRd;
  logic wdogOverflow;
  logic [7:0] rotRes;
  logic rotCarry;

  // the byte for a rotate is fetched from the address in the bus write
  assign fileRdAddr = isInstr ? busInstr.operand[6:0] : faddr_q;
  assign fileWrEn = (execRot && instr_q.dest == rsso_pkg::DEST_FILE) ||
                    swWrFdata;
  assign fileWrAddr = execRot ? instr_q.operand[6:0] : faddr_q;
  assign fileWrData = execRot ? rotRes : pwdata[7:0];

  rsso_file_mem u_file (
    .mclk(mclk),
    .wrEn(fileWrEn),
    .wrAddr(fileWrAddr),
    .wrData(fileWrData),
    .rdAddr(fileRdAddr),
    .rdData(fileRd)
  );

  rsso_watchdog_counter u_wdog (
    .mclk(mclk),
    .rst(rst),
    .clear(execSleep),
    .prescale(wdogPre),
    .count(wdogCount),
    .overflow(wdogOverflow)
  );

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  logic [7:0] subLit;
  logic [7:0] subDiff;
  logic subCarry;
  logic subNibble;

  always_comb begin
    if (rotLeft) begin
      rotRes = {fileRd[6:0], flags_q.carry};
      rotCarry = fileRd[7];
    end else begin
      rotRes = {flags_q.carry, fileRd[7:1]};
      rotCarry = fileRd[0];
    end
  end

  assign subLit = busInstr.operand;
  assign subDiff = subLit - acc_q;
  assign subCarry = (acc_q <= subLit);
  assign subNibble = (acc_q[3:0] <= subLit[3:0]);

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= rsso_pkg::S_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      case (state_q)
        rsso_pkg::S_IDLE: begin
          if (access) begin
            prdata <= 32'h0000_0000;
            if (!mapped || refuseNow) begin
              pslverr <= 1'b1;
              pready <= 1'b1;
            end else if (issueNow && !busInstr.op[1]) begin
              state_q <= rsso_pkg::S_ROTATE;
            end else if (!pwrite &&
                         paddr == rsso_pkg::OFS_FDATA) begin
              state_q <= rsso_pkg::S_FILE_READ;
            end else begin
              pready <= 1'b1;
              if (!pwrite) begin
                prdata <= regRd;
              end
            end
          end
        end
        rsso_pkg::S_ROTATE: begin
          pready <= 1'b1;
          state_q <= rsso_pkg::S_IDLE;
        end
        rsso_pkg::S_FILE_READ: begin
          prdata <= {24'h000000, fileRd};
          pready <= 1'b1;
          state_q <= rsso_pkg::S_IDLE;
        end
        default: begin
          state_q <= rsso_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // instruction latch and file pointer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      instr_q <= '0;
    end else if (issueNow) begin
      instr_q <= busInstr;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      faddr_q <= 7'h00;
    end else if (swWrFaddr) begin
      faddr_q <= pwdata[6:0];
    end
  end

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_q <= 8'h00;
    end else if (execSub) begin
      acc_q <= subDiff;
    end else if (execRot && instr_q.dest == rsso_pkg::DEST_ACC) begin
      acc_q <= rotRes;
    end else if (swWrAcc) begin
      acc_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // arithmetic flags: instructions and software writes never coincide,
  // since a rotate finishes while the bus is held off
  // one process owns the whole flag word so it has a single driver;
  // power status bits are read-only to software
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_q.carry <= 1'b0;
      flags_q.nibbleCarryFlag <= 1'b0;
      flags_q.zero <= 1'b0;
      flags_q.powerDownStatus <= rsso_pkg::RST_POWER_DOWN;
      flags_q.timeoutStatus <= rsso_pkg::RST_TIMEOUT;
    end else begin
      if (execSub) begin
        flags_q.carry <= subCarry;
        flags_q.nibbleCarryFlag <= subNibble;
        flags_q.zero <= (subDiff == 8'h00);
      end else if (execRot) begin
        flags_q.carry <= rotCarry;
      end else if (swWrStatus) begin
        flags_q.carry <= pwdata[rsso_pkg::ST_CARRY];
        flags_q.nibbleCarryFlag <= pwdata[rsso_pkg::ST_NIBBLE_CARRY];
        flags_q.zero <= pwdata[rsso_pkg::ST_ZERO];
      end
      if (execSleep) begin
        flags_q.powerDownStatus <= 1'b0;
        flags_q.timeoutStatus <= 1'b1;
      end else if (wdogOverflow) begin
        // a watchdog expiry is recorded as a time-out
        flags_q.timeoutStatus <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sleep and oscillator control
  // ----------------------------------------------------------------
  // the watchdog keeps counting in sleep so its expiry can wake the core
  always_ff @(posedge mclk) begin
    if (rst) begin
      asleep_q <= 1'b0;
    end else if (execSleep) begin
      asleep_q <= 1'b1;
    end else if (swWake || wdogOverflow) begin
      asleep_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      oscRunning <= 1'b1;
    end else if (execSleep) begin
      oscRunning <= 1'b0;
    end else if (swWake || wdogOverflow) begin
      oscRunning <= 1'b1;
    end
  end

endmodule // rsso_core

`default_nettype wire

// file: testbench/rsso_core_props.sv
// assertion checker for rsso_core, watching only the top-level ports
// assumes an APB master that holds each request until pready is sampled
`timescale 1ns/1ps
`default_nettype none

module rsso_core_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic oscRunning
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // request tracking
  // ----------------------------------------------------------------
  // a rotate keeps the access phase open with pready low, so the
  // second edge of that phase must not count as a new request
  logic busy_q;
  logic take;
  logic instrWr;
  logic [1:0] op;
  assign take = psel && penable && !pready && !busy_q;
  assign instrWr = take && pwrite && paddr == rsso_pkg::OFS_INSTR;
  assign op = pwdata[13:12];

  always_ff @(posedge mclk) begin
    if (rst || pready) busy_q <= 1'b0;
    else if (take) busy_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_fast; pready && !pslverr; endsequence
  sequence s_slow; !pready ##1 s_fast; endsequence
  sequence s_refused; pready && pslverr && prdata == 32'h0; endsequence

  property p_rotate; instrWr && oscRunning && !op[1] |=> s_slow; endproperty
  a_rotate: assert property (p_rotate)
    else $error("rotate answer not after one execute cycle");
  property p_sub;
    instrWr && oscRunning && op == rsso_pkg::OPC_LITERAL_MINUS_ACC |=> s_fast;
  endproperty
  a_sub: assert property (p_sub)
    else $error("subtract answer late or refused");
  property p_sleep;
    instrWr && oscRunning && op == rsso_pkg::OPC_SLEEP
      |=> !oscRunning ##0 s_fast;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("oscillator still running after sleep");
  property p_refuse; instrWr && !oscRunning |=> s_refused; endproperty
  a_refuse: assert property (p_refuse)
    else $error("instruction accepted while asleep");
  property p_wake;
    take && pwrite && paddr == rsso_pkg::OFS_WAKE && pwdata[0] && !oscRunning
      |=> oscRunning ##0 s_fast;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake write did not restart the core");
  property p_fdata;
    take && !pwrite && paddr == rsso_pkg::OFS_FDATA |=> s_slow;
  endproperty
  a_fdata: assert property (p_fdata)
    else $error("file byte read answer timing off");
  property p_unmapped;
    take && (paddr > rsso_pkg::OFS_WDOG || paddr[1:0] != 2'h0) |=> s_refused;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse)
    else $error("pready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("pslverr without pready");
  property p_status;
    pready && psel && !pwrite && paddr == rsso_pkg::OFS_STATUS
      |-> prdata[5] == !oscRunning;
  endproperty
  a_status: assert property (p_status)
    else $error("asleep status disagrees with oscillator");
endmodule // rsso_core_props

bind rsso_core rsso_core_props u_props (.mclk(mclk), .rst(rst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .oscRunning(oscRunning));

`default_nettype wire

// file: testbench/rsso_core_test.sv
// self-checking bench for rsso_core: APB driver, note queue and monitor
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  failures++; $display("wrong value %s exp %h got %h", nm, e, g); end end

module rsso_core_test;
  typedef struct packed {
    logic [7:0] a;
    logic [32:0] v;
    logic [32:0] m;
  } rsso_note_t;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, oscRunning;
  logic [7:0] paddr, acc, v, k, r;
  logic [31:0] pwdata, prdata;
  logic [2:0] fl;
  logic [1:0] pt;
  logic c, op0, dst;
  logic [6:0] fa;
  rsso_note_t notes[$];
  rsso_note_t nt;
  int failures = 0;
  int num_checks = 0;
  int seed = 39734;

  rsso_core uut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oscRunning(oscRunning));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // monitor: every answered transfer consumes the oldest note
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst && psel && penable && pready === 1'b1) begin
      nt = notes.pop_front();
      `CHK($sformatf("reg_%h", nt.a), nt.v & nt.m, {pslverr, prdata} & nt.m)
    end
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d, input logic [31:0] e, input logic [31:0] m,
      input logic er);
    notes.push_back('{a, {er, e}, {1'b1, m}});
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge mclk);
    penable <= 1'b1;
    // no cycle count is assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 32'h0, 32'hffffffff, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0, e, 32'hffffffff, 1'b0);
  endtask

  task automatic ins(input logic [1:0] o, input logic d, input logic [7:0] x);
    wr(rsso_pkg::OFS_INSTR, {18'h0, o, 3'h0, d, x});
  endtask

  // status word from the model: time-out, power-down, zero, nibble, carry
  function automatic logic [31:0] stv();
    return {27'h0, pt, fl};
  endfunction

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    summarize();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    acc = 8'h0;
    fl = 3'h0;
    pt = 2'h3;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(rsso_pkg::OFS_STATUS, stv());
    rd(rsso_pkg::OFS_ACC, 32'h0);
    $display("test reset done");
    // first two passes hit the lowest and highest file address
    for (int i = 0; i < 40; i++) begin
      fa = (i == 0) ? 7'h0 : (i == 1) ? rsso_pkg::FILE_ADDR_MAX
        : 7'($random(seed));
      v = 8'($random(seed));
      fl = 3'($random(seed));
      {op0, dst} = 2'($random(seed));
      wr(rsso_pkg::OFS_STATUS, stv());
      wr(rsso_pkg::OFS_FADDR, {25'h0, fa});
      wr(rsso_pkg::OFS_FDATA, {24'h0, v});
      ins({1'b0, op0}, dst, {1'b0, fa});
      c = op0 ? v[0] : v[7];
      r = op0 ? {fl[0], v[7:1]} : {v[6:0], fl[0]};
      fl[0] = c;
      if (dst)
        rd(rsso_pkg::OFS_FDATA, {24'h0, r});
      else
        acc = r;
      rd(rsso_pkg::OFS_ACC, {24'h0, acc});
      rd(rsso_pkg::OFS_STATUS, stv());
    end
    $display("test rotate done");
    // zero result, largest literal and equal operands come first
    for (int i = 0; i < 40; i++) begin
      acc = (i < 2) ? 8'h0 : 8'($random(seed));
      k = (i == 1) ? rsso_pkg::LITERAL_MAX : (i == 0) ? 8'h0
        : 8'($random(seed));
      if (i == 2)
        k = acc;
      wr(rsso_pkg::OFS_ACC, {24'h0, acc});
      ins(rsso_pkg::OPC_LITERAL_MINUS_ACC, 1'b0, k);
      r = k - acc;
      fl = {r == 8'h0, acc[3:0] <= k[3:0], acc <= k};
      acc = r;
      rd(rsso_pkg::OFS_ACC, {24'h0, acc});
      rd(rsso_pkg::OFS_STATUS, stv());
    end
    $display("test subtract done");
    ins(rsso_pkg::OPC_SLEEP, 1'b0, 8'h0);
    `CHK("oscRunning", 1'b0, oscRunning)
    pt = 2'h2;
    rd(rsso_pkg::OFS_WAKE, 32'h1);
    rd(rsso_pkg::OFS_STATUS, stv() | 32'h20);
    // prescaler has run a few cycles since the clear; the count must not
    apb(rsso_pkg::OFS_WDOG, 1'b0, 32'h0, 32'h0, 32'hfff0, 1'b0);
    apb(rsso_pkg::OFS_INSTR, 1'b1, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    rd(rsso_pkg::OFS_ACC, {24'h0, acc});
    wr(rsso_pkg::OFS_WAKE, 32'h1);
    `CHK("oscRunning", 1'b1, oscRunning)
    rd(rsso_pkg::OFS_STATUS, stv());
    $display("test sleep done");
    apb(8'h1c, 1'b0, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    apb(8'h1c, 1'b1, 32'h5a, 32'h0, 32'hffffffff, 1'b1);
    $display("test unmapped done");
    summarize();
  end
endmodule // rsso_core_test

`default_nettype wire
